// ### i2cm_fifo.sv
// Purpose: Small synchronous FIFO for received bytes
// Assumes: Single clock
// Notes:   Width and depth shape the storage
`timescale 1ns/1ps
module i2cm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             i_clock,
    input  wire logic             i_reset_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign o_in_ready  = (count != (AW+1)'(DEPTH));
    assign o_out_valid = (count != '0);
    assign o_out_data  = mem[rd_ptr];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : i2cm_fifo

// ### i2cm_master.sv
// Purpose: Master sequencer: start, byte transfer, ack, stop, arbitration
// Assumes: Line inputs are asynchronous; enable requests are one-cycle pulses
// Notes:   Received bytes pass a 4-word FIFO before the transfer buffer
`timescale 1ns/1ps
module i2cm_master
    import i2cm_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_reset_n,
    input  wire logic       i_port_enable,
    input  wire logic [7:0] i_address_reload_register,
    input  wire logic       i_start_enable_set,
    input  wire logic       i_receive_enable_set,
    input  wire logic       i_ack_enable_set,
    input  wire logic       i_stop_enable_set,
    input  wire logic       i_ack_data,
    input  wire logic       i_buffer_write,
    input  wire logic [7:0] i_buffer_wdata,
    input  wire logic       i_buffer_read,
    input  wire logic       i_clear_serial_interrupt,
    input  wire logic       i_clear_bus_collision,
    input  wire logic       i_clear_write_collision,
    input  wire logic       i_interrupt_enable,
    input  wire logic       i_sleep,
    input  wire logic       i_scl_in,
    input  wire logic       i_sda_in,
    output logic            o_scl_oe,
    output logic            o_scl_out,
    output logic            o_sda_oe,
    output logic            o_sda_out,
    output logic [7:0]      o_transfer_buffer,
    output logic            o_buffer_full,
    output logic            o_write_collision_flag,
    output logic            o_serial_interrupt_flag,
    output logic            o_bus_collision_flag,
    output logic            o_ack_status,
    output logic            o_start_enable,
    output logic            o_receive_enable,
    output logic            o_ack_enable,
    output logic            o_stop_enable,
    output logic            o_start_detected,
    output logic            o_stop_detected,
    output logic            o_wake
);
    i2cm_state_e state;
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic        scl;
    logic        sda;
    logic        scl_d;
    logic        sda_d;
    logic [7:0]  baud_generator;
    logic        brg_run;
    logic        tick;
    logic [7:0]  shift_register;
    logic [3:0]  bit_cnt;
    logic        phase_high;
    logic        is_read;
    logic        sda_drv_low;
    logic        scl_drv_low;
    logic        lost;
    logic        busy_wr;
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [7:0]  fifo_out_data;
    logic        take_fifo;
    logic        col_event;
    logic        si_event;

    // Two-stage synchronisers on the bus lines
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], i_scl_in};
            sda_sync <= {sda_sync[0], i_sda_in};
            scl_d    <= scl_sync[1];
            sda_d    <= sda_sync[1];
        end
    end
    assign scl = scl_sync[1];
    assign sda = sda_sync[1];

    assign tick = brg_run && (baud_generator == BRG_RESET);
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            baud_generator <= BRG_RESET;
        end else if (!brg_run || tick) begin
            baud_generator <= i_address_reload_register;
        end else begin
            baud_generator <= baud_generator - 8'h01;
        end
    end

    // Buffer writes are refused while any sequence is under way
    assign busy_wr = (state != ST_IDLE) && (state != ST_HOLD);

    assign take_fifo = fifo_out_valid && !o_buffer_full;

    // Main sequencer
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state          <= ST_IDLE;
            brg_run        <= 1'b0;
            shift_register <= BUF_RESET;
            bit_cnt        <= '0;
            phase_high     <= 1'b0;
            is_read        <= 1'b0;
            sda_drv_low    <= 1'b0;
            scl_drv_low    <= 1'b0;
            col_event      <= 1'b0;
            si_event       <= 1'b0;
            fifo_in_valid  <= 1'b0;
            o_ack_status   <= 1'b0;
            o_start_enable <= 1'b0;
            o_receive_enable <= 1'b0;
            o_ack_enable   <= 1'b0;
            o_stop_enable  <= 1'b0;
            lost           <= 1'b0;
        end else begin
            col_event     <= 1'b0;
            si_event      <= 1'b0;
            fifo_in_valid <= fifo_in_valid && !fifo_in_ready;
            if (!i_port_enable) begin
                state       <= ST_IDLE;
                brg_run     <= 1'b0;
                sda_drv_low <= 1'b0;
                scl_drv_low <= 1'b0;
                o_start_enable   <= 1'b0;
                o_receive_enable <= 1'b0;
                o_ack_enable     <= 1'b0;
                o_stop_enable    <= 1'b0;
            end else begin
                unique case (state)
                    ST_IDLE, ST_HOLD: begin
                        if (i_start_enable_set) begin
                            o_start_enable <= 1'b1;
                            if (!sda || !scl) begin
                                col_event      <= 1'b1;
                                o_start_enable <= 1'b0;
                                sda_drv_low    <= 1'b0;
                                scl_drv_low    <= 1'b0;
                                state          <= ST_IDLE;
                            end else begin
                                lost    <= 1'b0;
                                brg_run <= 1'b1;
                                state   <= ST_START;
                            end
                        end else if (i_buffer_write) begin
                            shift_register <= i_buffer_wdata;
                            is_read        <= i_buffer_wdata[0];
                            bit_cnt        <= '0;
                            phase_high     <= 1'b0;
                            brg_run        <= 1'b1;
                            sda_drv_low    <= !i_buffer_wdata[7];
                            lost           <= 1'b0;
                            state          <= ST_TX;
                        end else if (i_receive_enable_set) begin
                            o_receive_enable <= 1'b1;
                            bit_cnt     <= '0;
                            phase_high  <= 1'b0;
                            sda_drv_low <= 1'b0;
                            brg_run     <= 1'b1;
                            state       <= ST_RX;
                        end else if (i_ack_enable_set) begin
                            o_ack_enable <= 1'b1;
                            scl_drv_low  <= 1'b1;
                            sda_drv_low  <= !i_ack_data;
                            phase_high   <= 1'b0;
                            brg_run      <= 1'b1;
                            state        <= ST_ACK;
                        end else if (i_stop_enable_set) begin
                            o_stop_enable <= 1'b1;
                            scl_drv_low   <= 1'b1;
                            sda_drv_low   <= 1'b1;
                            state         <= ST_STOP;
                        end
                    end
                    ST_START: begin
                        if (!scl) begin
                            col_event      <= 1'b1;
                            o_start_enable <= 1'b0;
                            sda_drv_low    <= 1'b0;
                            scl_drv_low    <= 1'b0;
                            brg_run        <= 1'b0;
                            state          <= ST_IDLE;
                        // Early data fall or count end
                        end else if (!sda || tick) begin
                            sda_drv_low <= 1'b1;
                            brg_run     <= 1'b0;
                            state       <= ST_STRT2;
                        end
                    end
                    ST_STRT2: begin
                        brg_run <= 1'b1;
                        if (tick) begin
                            scl_drv_low    <= 1'b1;
                            brg_run        <= 1'b0;
                            o_start_enable <= 1'b0;
                            si_event       <= 1'b1;
                            state          <= ST_HOLD;
                        end
                    end
                    ST_TX, ST_RX: begin
                        if (!phase_high) begin
                            scl_drv_low <= 1'b1;
                            if (tick) begin
                                scl_drv_low <= 1'b0;
                                phase_high  <= 1'b1;
                                brg_run     <= 1'b0;
                            end
                        end else if (scl) begin
                            brg_run <= 1'b1;
                            if (state == ST_TX && bit_cnt < LAST_BIT && !sda_drv_low
                                && !sda) begin
                                col_event   <= 1'b1;
                                lost        <= 1'b1;
                                sda_drv_low <= 1'b0;
                                scl_drv_low <= 1'b0;
                                brg_run     <= 1'b0;
                                state       <= ST_IDLE;
                            end else if (tick) begin
                                scl_drv_low <= 1'b1;
                                phase_high  <= 1'b0;
                                bit_cnt     <= bit_cnt + 4'h1;
                                if (state == ST_RX) begin
                                    shift_register <= {shift_register[6:0], sda};
                                    if (bit_cnt == LAST_BIT - 4'h1) begin
                                        fifo_in_valid    <= 1'b1;
                                        o_receive_enable <= 1'b0;
                                        si_event         <= 1'b1;
                                        brg_run          <= 1'b0;
                                        state            <= ST_HOLD;
                                    end
                                end else if (bit_cnt == LAST_BIT) begin
                                    o_ack_status <= sda;
                                    si_event     <= 1'b1;
                                    brg_run      <= 1'b0;
                                    state        <= ST_HOLD;
                                end else begin
                                    shift_register <= {shift_register[6:0], 1'b1};
                                    sda_drv_low <= (bit_cnt == LAST_BIT - 4'h1) ? 1'b0
                                                                               : !shift_register[6];
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        if (!phase_high) begin
                            if (tick) begin
                                scl_drv_low <= 1'b0;
                                phase_high  <= 1'b1;
                                brg_run     <= 1'b0;
                            end
                        end else if (scl) begin
                            brg_run <= 1'b1;
                            if (!sda_drv_low && !sda) begin
                                col_event    <= 1'b1;
                                o_ack_enable <= 1'b0;
                                brg_run      <= 1'b0;
                                state        <= ST_IDLE;
                            end else if (tick) begin
                                scl_drv_low  <= 1'b1;
                                o_ack_enable <= 1'b0;
                                si_event     <= 1'b1;
                                brg_run      <= 1'b0;
                                state        <= ST_HOLD;
                            end
                        end
                    end
                    ST_STOP: begin
                        brg_run <= !sda;
                        if (tick) begin
                            scl_drv_low <= 1'b0;
                            brg_run     <= 1'b0;
                            state       <= ST_STOP2;
                        end
                    end
                    ST_STOP2: begin
                        brg_run <= scl;
                        if (tick) begin
                            sda_drv_low <= 1'b0;
                            brg_run     <= 1'b0;
                            state       <= ST_STOP3;
                        end
                    end
                    ST_STOP3: begin
                        brg_run <= o_stop_detected;
                        if (tick) begin
                            o_stop_enable <= 1'b0;
                            si_event      <= 1'b1;
                            brg_run       <= 1'b0;
                            state         <= ST_IDLE;
                        end
                    end
                endcase
            end
            if (lost && scl && !sda_d && sda) begin
                si_event <= 1'b1;
                lost     <= 1'b0;
            end
        end
    end

    // Drive lines: output low when enabled
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_scl_oe  <= 1'b0;
            o_sda_oe  <= 1'b0;
            o_scl_out <= 1'b0;
            o_sda_out <= 1'b0;
        end else begin
            o_scl_oe  <= scl_drv_low;
            o_sda_oe  <= sda_drv_low;
            o_scl_out <= 1'b0;
            o_sda_out <= 1'b0;
        end
    end

    // Bus condition detection
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_start_detected <= 1'b0;
            o_stop_detected  <= 1'b0;
        end else if (!i_port_enable) begin
            o_start_detected <= 1'b0;
            o_stop_detected  <= 1'b0;
        end else if (scl && scl_d && sda_d && !sda) begin
            o_start_detected <= 1'b1;
            o_stop_detected  <= 1'b0;
        end else if (scl && scl_d && !sda_d && sda) begin
            o_start_detected <= 1'b0;
            o_stop_detected  <= 1'b1;
        end
    end

    // Transfer buffer, full and collision flags
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_transfer_buffer      <= BUF_RESET;
            o_buffer_full          <= 1'b0;
            o_write_collision_flag <= 1'b0;
            o_serial_interrupt_flag <= 1'b0;
            o_bus_collision_flag   <= 1'b0;
            o_wake                 <= 1'b0;
        end else begin
            if (i_buffer_write && busy_wr) begin
                o_write_collision_flag <= 1'b1;
            end else if (i_clear_write_collision) begin
                o_write_collision_flag <= 1'b0;
            end
            if (col_event) begin
                o_buffer_full <= 1'b0;
            end else if (take_fifo) begin
                o_transfer_buffer <= fifo_out_data;
                o_buffer_full     <= 1'b1;
            end else if (i_buffer_write && !busy_wr) begin
                o_transfer_buffer <= i_buffer_wdata;
                o_buffer_full     <= 1'b1;
            end else if (i_buffer_read || (state == ST_TX && bit_cnt == LAST_BIT)) begin
                o_buffer_full <= 1'b0;
            end
            if (si_event || (i_interrupt_enable && scl && !sda_d && sda && lost)) begin
                o_serial_interrupt_flag <= 1'b1;
            end else if (i_clear_serial_interrupt) begin
                o_serial_interrupt_flag <= 1'b0;
            end
            if (col_event) begin
                o_bus_collision_flag <= 1'b1;
            end else if (i_clear_bus_collision) begin
                o_bus_collision_flag <= 1'b0;
            end
            o_wake <= i_sleep && i_interrupt_enable && o_serial_interrupt_flag;
        end
    end

    i2cm_fifo #(
        .WIDTH (BYTE_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clock     (i_clock),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (fifo_in_valid),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (shift_register),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (!o_buffer_full),
        .o_out_data  (fifo_out_data)
    );
endmodule : i2cm_master

// ### i2cm_master_sva.sv
// Purpose: Port assertions for the master sequencer
// Assumes: One clock, async active-low reset
// Notes:   Bound to every master instance
`timescale 1ns/1ps
module i2cm_master_sva (
    input wire logic       i_clock, i_reset_n, i_port_enable, i_buffer_write, i_ack_data,
    input wire logic       i_receive_enable_set, i_sleep, i_interrupt_enable, o_scl_oe, o_sda_oe,
    input wire logic       o_write_collision_flag, o_serial_interrupt_flag, o_bus_collision_flag,
    input wire logic       o_start_enable, o_receive_enable, o_ack_enable, o_stop_enable,
    input wire logic       o_stop_detected, o_wake,
    input wire logic [7:0] o_transfer_buffer
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    wire logic busy  = o_ack_enable || o_stop_enable;
    wire logic rbusy = busy || o_receive_enable;
    wire logic wk    = i_sleep && i_interrupt_enable && o_serial_interrupt_flag;
    property p_write_collision_flag; i_buffer_write && rbusy |=> o_write_collision_flag; endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision flag missed");
    property p_keep; i_buffer_write && busy |=> $stable(o_transfer_buffer); endproperty
    a_keep: assert property (p_keep) else $error("buffer changed");
    property p_rcv; i_receive_enable_set && busy |=> !$rose(o_receive_enable); endproperty
    a_rcv: assert property (p_rcv) else $error("receive taken while busy");
    property p_wake; wk |-> ##[0:1] o_wake; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_stop; $fell(o_stop_enable) && i_port_enable
        |-> o_stop_detected ##[0:2] o_serial_interrupt_flag; endproperty
    a_stop: assert property (p_stop) else $error("stop end wrong");
    property p_rel; $rose(o_bus_collision_flag) |-> ##[0:2] !(o_scl_oe || o_sda_oe); endproperty
    a_rel: assert property (p_rel) else $error("lines held after collision");
    property p_clr; $rose(o_bus_collision_flag) |-> ##[0:1] !(busy || o_start_enable); endproperty
    a_clr: assert property (p_clr) else $error("enables kept");
    property p_ack; $rose(o_ack_enable) |-> ##[1:3] o_scl_oe && o_sda_oe == !i_ack_data; endproperty
    a_ack: assert property (p_ack) else $error("ack bit wrong");
    c_stop: cover property ($fell(o_stop_enable));
    c_ack: cover property ($fell(o_ack_enable));
    c_bcl: cover property ($rose(o_bus_collision_flag));
endmodule : i2cm_master_sva
bind i2cm_master i2cm_master_sva i2cm_master_sva_i (.*);

// ### i2cm_pkg.sv
// Purpose: Constants for the two-wire master sequencer
// Assumes: 125 MHz system clock, open-drain lines
// Notes:   Control and status bits are plain ports
// What this block does
// - Buffer write while receiving sets collision flag
// - Read address: interrupt and ack after ninth
// - Receive byte; eighth fall sets interrupt, full
// - Ack enable drives ack data, holds clock
// - Ack: release clock, wait period, pull low
// - Ack end clears enable, holds clock low in ST_HOLD
// - Buffer write during ack sets collision flag
// - Stop: data low, clock up, data up
// - Stop seen sets bit, later interrupt
// - Buffer write during stop sets collision flag
// - Clock held low after ninth falling edge
// - Completed byte wakes processor if enabled
// - Reset or disable clears detection bits
// - Claim bus only when free; stop interrupts
// - Released one read low sets bus collision
// - Transmit collision halts, clears full, releases
// - Condition collision aborts, clears enables
// - After arbitration loss, stop sets interrupt
// - Buffer write after collision restarts bit one
// - Lines low at start: abort, collision
// - Clock low during first start count collides
// - Early data fall resets generator count
// - Generator loads reload value, counts down
// - Receive enable ignored outside ST_IDLE and ST_HOLD
package i2cm_pkg;
    localparam int          BYTE_BITS   = 8;
    localparam logic [3:0]  LAST_BIT    = 4'h8;
    localparam logic [7:0]  BRG_RESET   = 8'h00;
    localparam logic [7:0]  BUF_RESET   = 8'h00;
    localparam int          FIFO_DEPTH  = 4;

    typedef enum logic [9:0] {
        ST_IDLE  = 10'h001,
        ST_START = 10'h002,
        ST_STRT2 = 10'h004,
        ST_TX    = 10'h008,
        ST_RX    = 10'h010,
        ST_ACK   = 10'h020,
        ST_STOP  = 10'h040,
        ST_STOP2 = 10'h080,
        ST_STOP3 = 10'h100,
        ST_HOLD  = 10'h200
    } i2cm_state_e;
endpackage : i2cm_pkg

// ### i2cm_slave_model.sv
// Purpose: Slave that acks and returns a fixed byte on reads
// Assumes: Lines sampled on the system clock
// Notes:   Bit count restarts on every start or stop
`timescale 1ns/1ps
module i2cm_slave_model #(parameter logic [7:0] READ_BYTE = 8'hA5) (
    input  wire logic i_clock,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_sda_oe
);
    logic [3:0] cnt = 4'hF;
    logic       ps = 1'b1, pd = 1'b1, first = 1'b1, rw = 1'b0;
    always @(posedge i_clock) begin
        ps <= i_scl;
        pd <= i_sda;
        if (ps && i_scl && pd != i_sda) begin
            cnt   <= 4'hF;
            first <= 1'b1;
        end else if (ps && !i_scl) begin
            cnt   <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
            first <= first && cnt != 4'h8;
        end else if (!ps && i_scl && first && cnt == 4'h7) begin
            rw <= i_sda;
        end
    end
    assign o_sda_oe = (cnt == 4'h8 && (first || !rw))
        || (!first && rw && cnt < 4'h8 && !READ_BYTE[3'h7 - cnt[2:0]]);
endmodule : i2cm_slave_model

// ### tb_i2c_master_ack_stop_arbitration.sv
// Purpose: Self-checking bench for the master sequencer
// Assumes: Pulled-up lines, slave model on the bus
// Notes:   Seeded reload, address and ack bit
`timescale 1ns/1ps
module tb_i2c_master_ack_stop_arbitration;
    localparam logic [7:0] RD = 8'hA5;
    logic       i_clock = 1'b0, i_reset_n = 1'b0, en = 1'b1, sl = 1'b0, ad = 1'b0, frc = 1'b0;
    logic [8:0] rq = 9'h000;
    logic       ie = 1'b1;
    logic [7:0] rel = 8'h03, wd = 8'h00;
    int         seed = 27, n_fail = 0, checks_done = 0;
    wire logic  o_scl_oe, o_sda_oe, o_buffer_full, o_write_collision_flag, o_ack_status, s_oe;
    wire logic  o_serial_interrupt_flag, o_bus_collision_flag, o_start_enable, o_ack_enable;
    wire logic  o_stop_enable, o_start_detected, o_stop_detected, o_wake;
    wire logic  [7:0] o_transfer_buffer;
    wire logic  scl = !o_scl_oe;
    wire logic  sda = !(o_sda_oe || s_oe || frc);
    wire logic  [2:0] ws = {!o_stop_enable, !o_ack_enable, o_serial_interrupt_flag};
    always #4 i_clock = !i_clock;
    i2cm_master i2cm_master_i (.*, .i_port_enable(en), .i_address_reload_register(rel),
        .i_start_enable_set(rq[0]), .i_receive_enable_set(rq[1]), .i_ack_enable_set(rq[2]),
        .i_stop_enable_set(rq[3]), .i_buffer_write(rq[4]), .i_buffer_read(rq[5]),
        .i_clear_serial_interrupt(rq[6]), .i_clear_bus_collision(rq[7]), .i_sleep(sl),
        .i_clear_write_collision(rq[8]), .i_ack_data(ad), .i_buffer_wdata(wd),
        .i_interrupt_enable(ie), .i_scl_in(scl), .i_sda_in(sda),
        .o_scl_out(), .o_sda_out(), .o_receive_enable());
    i2cm_slave_model i2cm_slave_model_i (.i_clock(i_clock), .i_scl(scl), .i_sda(sda),
        .o_sda_oe(s_oe));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Stop seen and interrupt set; wake only when sleeping with interrupt enabled
    function automatic logic [7:0] stop_exp(input logic s, input logic e);
        return {5'h00, 2'h3, s && e};
    endfunction : stop_exp
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : tick
    task automatic req(input int k);
        rq[k] <= 1'b1;
        tick(1);
        rq[k] <= 1'b0;
        tick(1);
    endtask : req
    task automatic wt(input int k);
        int i;
        for (i = 0; i < 4000 && ws[k] !== 1'b1; i++) tick(1);
        if (i == 4000) begin
            n_fail++;
            complete_run();
        end
    endtask : wt
    initial begin
        tick(10);
        i_reset_n <= 1'b1;
        rel <= 8'h03 + {6'h00, 2'($random(seed))};
        tick(3);
        chk({o_scl_oe, o_sda_oe, o_start_detected, o_stop_detected}, 8'h00);
        for (int r = 0; r < 4; r++) begin
            chk(o_start_detected && !o_stop_detected, 8'h00);
            sl <= r[0];
            ie <= r[1];
            req(0);
            wt(0);
            req(6);
            wd <= {7'($random(seed)), 1'b1};
            req(4);
            wt(0);
            chk(o_ack_status, 8'h00);
            req(6);
            req(1);
            req(4);
            chk(o_write_collision_flag, 8'h01);
            req(8);
            wt(0);
            tick(2);
            chk({o_buffer_full, o_scl_oe}, 8'h03);
            chk(o_transfer_buffer, RD);
            req(5);
            req(6);
            ad <= 1'($random(seed));
            req(2);
            req(4);
            chk(o_write_collision_flag, 8'h01);
            chk(o_transfer_buffer, RD);
            req(8);
            wt(1);
            tick(2);
            chk(o_serial_interrupt_flag, 8'h01);
            req(6);
            req(3);
            req(4);
            chk(o_write_collision_flag, 8'h01);
            req(1);
            req(8);
            wt(2);
            tick(2);
            chk({o_stop_detected, o_serial_interrupt_flag, o_wake},
                stop_exp(sl, ie));
            req(6);
            $display("round %0d done", r);
        end
        // Another master holds data low while a one is sent
        req(0);
        wt(0);
        req(6);
        frc <= 1'b1;
        wd  <= 8'hFF;
        req(4);
        tick(40);
        chk({o_bus_collision_flag, o_buffer_full, o_scl_oe, o_sda_oe}, 8'h08);
        frc <= 1'b0;
        tick(6);
        chk(o_serial_interrupt_flag, 8'h01);
        req(6);
        req(7);
        frc <= 1'b1;
        tick(3);
        req(0);
        tick(3);
        chk({o_bus_collision_flag, o_start_enable}, 8'h02);
        frc <= 1'b0;
        req(7);
        en <= 1'b0;
        tick(3);
        chk({o_start_detected, o_stop_detected}, 8'h00);
        $display("arbitration, collision and disable done");
        complete_run();
    end
endmodule : tb_i2c_master_ack_stop_arbitration
